// ---- logic/tcorm_pkg.sv ----
package tcorm_pkg;

   localparam int          NUM_CH              = 10;
   localparam logic [15:0] CH_MASK             = 16'h03FF;

   // Holding register addresses as seen on the request port.
   localparam logic [15:0] ADDR_GLOBAL_ERROR   = 16'h9C42;
   localparam logic [15:0] ADDR_OUTPUT_DRIVE   = 16'h9C43;
   localparam logic [15:0] ADDR_CHANNEL_ERROR  = 16'h9C44;
   localparam logic [15:0] ADDR_LOAD_SHORT     = 16'h9C47;
   localparam logic [15:0] ADDR_SUPPLY_MEASURE = 16'h9C49;
   localparam logic [15:0] ADDR_NODE_PARITY    = 16'h9C4A;
   localparam logic [15:0] ADDR_RATE_DELAY     = 16'h9C4B;
   localparam logic [15:0] ADDR_LED_CONTROL    = 16'h9C4C;
   localparam logic [15:0] ADDR_DIAG_ENABLE    = 16'h9C4F;
   localparam logic [15:0] ADDR_SUPPLY_THRESH  = 16'h9C50;
   localparam logic [15:0] ADDR_COMMAND        = 16'h9C58;
   localparam logic [15:0] ADDR_CAPTURE        = 16'h9C59;

   localparam logic [15:0] CMD_MODULE_RESET    = 16'hC1A0;
   localparam logic [15:0] CMD_SWITCH_CAPTURE  = 16'hBDAC;

   // Global error register bit positions, and the supply monitor enable bit of the LED control register.
   localparam int          GE_SHORT_BIT        = 0;
   localparam int          GE_OUTPUT_ERR_BIT   = 3;
   localparam int          GE_SUPPLY_LOW_BIT   = 6;
   localparam int          LED_SUPPLY_MON_BIT  = 1;

   // Field positions inside the two packed configuration words.
   localparam int          HI_MSB              = 15;
   localparam int          HI_LSB              = 8;
   localparam int          LO_MSB              = 7;
   localparam int          LO_LSB              = 0;

   localparam logic [7:0]  NODE_ADDR_RST       = 8'h01;
   localparam logic [7:0]  NODE_ADDR_INVALID   = 8'h00;
   localparam logic [7:0]  PARITY_RST          = 8'h00;
   localparam logic [7:0]  PARITY_NONE         = 8'h00;
   localparam logic [7:0]  REPLY_DELAY_RST     = 8'h00;
   localparam logic [7:0]  SUPPLY_THRESH_RST   = 8'h00;
   localparam logic [15:0] WORD_ZERO           = 16'h0000;

   // Line rate codes.
   localparam logic [7:0]  RATE_4800           = 8'h00;
   localparam logic [7:0]  RATE_9600           = 8'h01;
   localparam logic [7:0]  RATE_19200          = 8'h02;
   localparam logic [7:0]  RATE_38400          = 8'h03;
   localparam logic [7:0]  RATE_57600          = 8'h04;
   localparam logic [7:0]  RATE_115200         = 8'h05;
   localparam logic [7:0]  RATE_1200           = 8'h06;
   localparam logic [7:0]  RATE_2400           = 8'h07;
   localparam logic [7:0]  RATE_RST            = RATE_38400;

endpackage : tcorm_pkg

// ---- logic/tcorm_register_bank.sv ----
// Behaviour
// - Channel error flag is raised only while its diagnostic enable bit is set.
// - A channel error flag stays set until the master writes zero to it or writes the module reset command.
// - Global output-error bit 3 is high while any channel error flag is one.
// - Global output-error bit clears only once all ten flags are zero, by zero writes or the module reset command.
// - Short register holds one flag per load; any flag forces global bit 0.
// - Address-and-parity bits 15:8 hold node address, valid 1 to 255.
// - Address-and-parity bits 7:0 select parity, zero meaning no parity.
// - Baud-and-delay bits 15:8 encode line rate, codes 0 to 7.
// - Baud-and-delay bits 7:0 set the reply pause, 0 to 255.
// - Writing 0xC1A0 to the command register clears outputs, diagnostic enables, error flags, supply monitor enable and command word, not other settings.
// - Writing 0xBDAC to the command register captures the DIP switches.
// - Capture register bits 7:6 show switches 1 and 2; bits 15:8 unused.
// - Capture register bits 5:0 show switches 3 to 8 after capture.
// - Supply measurement register reports load supply in tenths of a volt.
// - Fault lamp lights on low supply when LED control bit 1 enables it.
// - Output register drives one load per bit 0 to 9; bits 15:10 unused.
// - Diagnostic enable bits 0 to 9 switch error detection per channel.
// - Global error bit 0 reads one when any load is short-circuited.
module tcorm_register_bank
(
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   input  wire logic        req_valid,
   input  wire logic        req_write,
   input  wire logic [15:0] req_addr,
   input  wire logic [15:0] req_wdata,
   output logic             rsp_valid,
   output logic [15:0]      rsp_rdata,
   output logic             rsp_unmapped,
   input  wire logic [9:0]  channel_fault_pin,
   input  wire logic [9:0]  load_short_pin,
   input  wire logic [7:0]  dip_switch_pin,
   input  wire logic [15:0] supply_sample,
   output logic [9:0]       switched_channels_1_to_10,
   output logic             fault_indicator_lamp,
   output logic [7:0]       node_address,
   output logic [7:0]       parity_select,
   output logic [7:0]       line_rate_code,
   output logic [7:0]       reply_delay,
   output logic             module_reset_pulse
);

   logic [9:0]  fault_meta;
   logic [9:0]  fault_sync;
   logic [9:0]  short_meta;
   logic [9:0]  short_sync;
   logic [7:0]  dip_meta;
   logic [7:0]  dip_sync;
   logic [9:0]  diag_enable;
   logic [9:0]  error_flags;
   logic [9:0]  next_error_flags;
   logic [15:0] supply_measure;
   logic [7:0]  supply_thresh;
   logic        supply_mon_en;
   logic [15:0] command_word;
   logic [7:0]  switch_capture;
   logic        soft_reset;
   logic        wr_en;
   logic        rd_en;
   logic        supply_low;
   logic        any_error;
   logic        any_short;
   logic [15:0] global_error;
   logic [15:0] next_rdata;
   logic        next_unmapped;

   // Packs a ten-channel field into a holding word with the unused bits at zero.
   function automatic logic [15:0] tcorm_chan_word(input logic [9:0] bits);
      tcorm_chan_word = {6'h00, bits};
   endfunction : tcorm_chan_word

   // Tells whether an address belongs to this bank.
   function automatic logic tcorm_mapped(input logic [15:0] addr);
      case (addr)
         tcorm_pkg::ADDR_GLOBAL_ERROR,
         tcorm_pkg::ADDR_OUTPUT_DRIVE,
         tcorm_pkg::ADDR_CHANNEL_ERROR,
         tcorm_pkg::ADDR_LOAD_SHORT,
         tcorm_pkg::ADDR_SUPPLY_MEASURE,
         tcorm_pkg::ADDR_NODE_PARITY,
         tcorm_pkg::ADDR_RATE_DELAY,
         tcorm_pkg::ADDR_LED_CONTROL,
         tcorm_pkg::ADDR_DIAG_ENABLE,
         tcorm_pkg::ADDR_SUPPLY_THRESH,
         tcorm_pkg::ADDR_COMMAND,
         tcorm_pkg::ADDR_CAPTURE: tcorm_mapped = 1'b1;
         default:                 tcorm_mapped = 1'b0;
      endcase
   endfunction : tcorm_mapped

   assign wr_en = req_valid & req_write;
   assign rd_en = req_valid & ~req_write;

   // Detector, short and switch lines come from outside the clock domain.
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         fault_meta <= '0;
         fault_sync <= '0;
         short_meta <= '0;
         short_sync <= '0;
         dip_meta   <= '0;
         dip_sync   <= '0;
      end
      else
      begin
         fault_meta <= channel_fault_pin;
         fault_sync <= fault_meta;
         short_meta <= load_short_pin;
         short_sync <= short_meta;
         dip_meta   <= dip_switch_pin;
         dip_sync   <= dip_meta;
      end
   end

   // The command decode is one cycle behind the write so the pulse leaves a flop.
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         soft_reset         <= 1'b0;
         module_reset_pulse <= 1'b0;
      end
      else
      begin
         soft_reset         <= wr_en && req_addr == tcorm_pkg::ADDR_COMMAND
                               && req_wdata == tcorm_pkg::CMD_MODULE_RESET;
         module_reset_pulse <= wr_en && req_addr == tcorm_pkg::ADDR_COMMAND
                               && req_wdata == tcorm_pkg::CMD_MODULE_RESET;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         switched_channels_1_to_10 <= '0;
      else if (soft_reset)
         switched_channels_1_to_10 <= '0;
      else if (wr_en && req_addr == tcorm_pkg::ADDR_OUTPUT_DRIVE)
         switched_channels_1_to_10 <= req_wdata[9:0];
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         diag_enable <= '0;
      else if (soft_reset)
         diag_enable <= '0;
      else if (wr_en && req_addr == tcorm_pkg::ADDR_DIAG_ENABLE)
         diag_enable <= req_wdata[9:0];
   end

   // A detection in the cycle of a zero write survives: the set term wins.
   always_comb
   begin
      next_error_flags = error_flags;
      if (wr_en && req_addr == tcorm_pkg::ADDR_CHANNEL_ERROR)
         next_error_flags = error_flags & req_wdata[9:0];
      next_error_flags = next_error_flags | (diag_enable & (fault_sync | short_sync));
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         error_flags <= '0;
      else if (soft_reset)
         error_flags <= '0;
      else
         error_flags <= next_error_flags;
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         node_address  <= tcorm_pkg::NODE_ADDR_RST;
         parity_select <= tcorm_pkg::PARITY_RST;
      end
      else if (wr_en && req_addr == tcorm_pkg::ADDR_NODE_PARITY)
      begin
         // Address zero is refused so the node cannot drop off the bus.
         if (req_wdata[tcorm_pkg::HI_MSB:tcorm_pkg::HI_LSB] != tcorm_pkg::NODE_ADDR_INVALID)
            node_address <= req_wdata[tcorm_pkg::HI_MSB:tcorm_pkg::HI_LSB];
         parity_select <= req_wdata[tcorm_pkg::LO_MSB:tcorm_pkg::LO_LSB];
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         line_rate_code <= tcorm_pkg::RATE_RST;
         reply_delay    <= tcorm_pkg::REPLY_DELAY_RST;
      end
      else if (wr_en && req_addr == tcorm_pkg::ADDR_RATE_DELAY)
      begin
         if (req_wdata[tcorm_pkg::HI_MSB:tcorm_pkg::HI_LSB] <= tcorm_pkg::RATE_2400)
            line_rate_code <= req_wdata[tcorm_pkg::HI_MSB:tcorm_pkg::HI_LSB];
         reply_delay <= req_wdata[tcorm_pkg::LO_MSB:tcorm_pkg::LO_LSB];
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         supply_mon_en <= 1'b0;
         supply_thresh <= tcorm_pkg::SUPPLY_THRESH_RST;
      end
      else if (soft_reset)
         supply_mon_en <= 1'b0;
      else if (wr_en && req_addr == tcorm_pkg::ADDR_LED_CONTROL)
         supply_mon_en <= req_wdata[tcorm_pkg::LED_SUPPLY_MON_BIT];
      else if (wr_en && req_addr == tcorm_pkg::ADDR_SUPPLY_THRESH)
         supply_thresh <= req_wdata[tcorm_pkg::LO_MSB:tcorm_pkg::LO_LSB];
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         supply_measure <= tcorm_pkg::WORD_ZERO;
      else
         supply_measure <= supply_sample;
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         command_word <= tcorm_pkg::WORD_ZERO;
      else if (soft_reset)
         command_word <= tcorm_pkg::WORD_ZERO;
      else if (wr_en && req_addr == tcorm_pkg::ADDR_COMMAND)
         command_word <= req_wdata;
   end

   // Switches are latched only on command, so a bumped switch never moves the reading.
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         switch_capture <= '0;
      else if (wr_en && req_addr == tcorm_pkg::ADDR_COMMAND
               && req_wdata == tcorm_pkg::CMD_SWITCH_CAPTURE)
         switch_capture <= dip_sync;
   end

   assign supply_low = supply_measure < {8'h00, supply_thresh};
   assign any_error  = |error_flags;
   assign any_short  = |short_sync;

   always_comb
   begin
      global_error = tcorm_pkg::WORD_ZERO;
      global_error[tcorm_pkg::GE_SHORT_BIT]      = any_short;
      global_error[tcorm_pkg::GE_OUTPUT_ERR_BIT] = any_error;
      global_error[tcorm_pkg::GE_SUPPLY_LOW_BIT] = supply_mon_en & supply_low;
   end

   // Lamp stays steady; the blink modes of the indicator are not built here.
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         fault_indicator_lamp <= 1'b0;
      else
         fault_indicator_lamp <= (supply_mon_en & supply_low) | any_error | any_short;
   end

   always_comb
   begin
      next_rdata    = tcorm_pkg::WORD_ZERO;
      next_unmapped = ~tcorm_mapped(req_addr);
      case (req_addr)
         tcorm_pkg::ADDR_GLOBAL_ERROR:   next_rdata = global_error;
         tcorm_pkg::ADDR_OUTPUT_DRIVE:   next_rdata = tcorm_chan_word(switched_channels_1_to_10);
         tcorm_pkg::ADDR_CHANNEL_ERROR:  next_rdata = tcorm_chan_word(error_flags);
         tcorm_pkg::ADDR_LOAD_SHORT:     next_rdata = tcorm_chan_word(short_sync);
         tcorm_pkg::ADDR_SUPPLY_MEASURE: next_rdata = supply_measure;
         tcorm_pkg::ADDR_NODE_PARITY:    next_rdata = {node_address, parity_select};
         tcorm_pkg::ADDR_RATE_DELAY:     next_rdata = {line_rate_code, reply_delay};
         tcorm_pkg::ADDR_LED_CONTROL:
            next_rdata[tcorm_pkg::LED_SUPPLY_MON_BIT] = supply_mon_en;
         tcorm_pkg::ADDR_DIAG_ENABLE:    next_rdata = tcorm_chan_word(diag_enable);
         tcorm_pkg::ADDR_SUPPLY_THRESH:  next_rdata = {8'h00, supply_thresh};
         tcorm_pkg::ADDR_COMMAND:        next_rdata = command_word;
         tcorm_pkg::ADDR_CAPTURE:        next_rdata = {8'h00, switch_capture};
         default:                        next_rdata = tcorm_pkg::WORD_ZERO;
      endcase
   end

   // Writes are answered too, with read data zero, so the framer sees every request close.
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rsp_valid    <= 1'b0;
         rsp_rdata    <= tcorm_pkg::WORD_ZERO;
         rsp_unmapped <= 1'b0;
      end
      else
      begin
         rsp_valid    <= req_valid;
         rsp_rdata    <= rd_en ? next_rdata : tcorm_pkg::WORD_ZERO;
         rsp_unmapped <= req_valid & next_unmapped;
      end
   end

   default clocking tcorm_cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);

   flag_gated_a: assert property (
      !$past(diag_enable[0]) && !$past(error_flags[0]) |-> !error_flags[0])
      else $error("Channel flag rose with diagnostics off.");
   flag_sticky_a: assert property (
      $past(error_flags[3]) && !$past(soft_reset)
      && !($past(wr_en) && $past(req_addr) == tcorm_pkg::ADDR_CHANNEL_ERROR
      && !$past(req_wdata[3])) |-> error_flags[3])
      else $error("Channel flag dropped without a zero write.");
   summary_err_a: assert property (
      rd_en && req_addr == tcorm_pkg::ADDR_GLOBAL_ERROR && (|error_flags)
      |=> rsp_rdata[tcorm_pkg::GE_OUTPUT_ERR_BIT])
      else $error("Summary bit low while a flag is set.");
   summary_clear_a: assert property (
      rd_en && req_addr == tcorm_pkg::ADDR_GLOBAL_ERROR
      |=> rsp_rdata[tcorm_pkg::GE_OUTPUT_ERR_BIT] == |$past(error_flags))
      else $error("Summary bit disagrees with the flags.");
   short_summary_a: assert property (
      rd_en && req_addr == tcorm_pkg::ADDR_GLOBAL_ERROR
      |=> rsp_rdata[tcorm_pkg::GE_SHORT_BIT] == |$past(short_sync))
      else $error("Short summary disagrees with the short flags.");
   node_addr_a: assert property (
      node_address != tcorm_pkg::NODE_ADDR_INVALID)
      else $error("Node address reached zero.");
   rate_range_a: assert property (
      line_rate_code <= tcorm_pkg::RATE_2400)
      else $error("Line rate code out of range.");
   reset_cmd_a: assert property (
      wr_en && req_addr == tcorm_pkg::ADDR_COMMAND && req_wdata == tcorm_pkg::CMD_MODULE_RESET
      |=> module_reset_pulse ##1 (switched_channels_1_to_10 == '0 && error_flags == '0))
      else $error("Reset command did not clear the module.");
   capture_a: assert property (
      wr_en && req_addr == tcorm_pkg::ADDR_COMMAND && req_wdata == tcorm_pkg::CMD_SWITCH_CAPTURE
      |=> switch_capture == $past(dip_sync))
      else $error("Switch capture missed.");
   capture_hold_a: assert property (
      !($past(wr_en) && $past(req_addr) == tcorm_pkg::ADDR_COMMAND) |-> $stable(switch_capture))
      else $error("Capture changed without a command.");
   lamp_supply_a: assert property (
      supply_mon_en && supply_low |=> fault_indicator_lamp)
      else $error("Lamp off during low supply.");
   output_write_a: assert property (
      wr_en && req_addr == tcorm_pkg::ADDR_OUTPUT_DRIVE && !soft_reset
      |=> switched_channels_1_to_10 == $past(req_wdata[9:0]))
      else $error("Output write not applied.");
   answer_a: assert property (
      req_valid |=> rsp_valid && (rsp_unmapped == !tcorm_mapped($past(req_addr))))
      else $error("Request not answered correctly.");
   ro_write_a: assert property (
      wr_en && req_addr == tcorm_pkg::ADDR_CAPTURE |=> $stable(switch_capture))
      else $error("Write to a read-only register changed it.");

   flag_clear_c: cover property (
      error_flags[0] ##1 (wr_en && req_addr == tcorm_pkg::ADDR_CHANNEL_ERROR) ##1 !error_flags[0]);
   soft_reset_c: cover property (module_reset_pulse);
   capture_c: cover property (
      wr_en && req_addr == tcorm_pkg::ADDR_COMMAND && req_wdata == tcorm_pkg::CMD_SWITCH_CAPTURE);
   lamp_c: cover property (supply_mon_en && supply_low ##1 fault_indicator_lamp);

endmodule : tcorm_register_bank

// ---- tb/tcorm_master_model.sv ----
module tcorm_master_model
(
   input  wire logic        ref_clk,
   input  wire logic        rsp_valid,
   input  wire logic [15:0] rsp_rdata,
   input  wire logic        rsp_unmapped,
   output logic             req_valid,
   output logic             req_write,
   output logic [15:0]      req_addr,
   output logic [15:0]      req_wdata
);
   timeunit 1ns;
   timeprecision 1ps;

   initial
   begin
      req_valid = 1'b0;
      req_write = 1'b0;
      req_addr  = 16'hA5A5;
      req_wdata = 16'h5A5A;
   end

   // Released address and data show the inverse, so a stale value is never mistaken for live.
   task automatic xfer(input logic w, input logic [15:0] a, input logic [15:0] d,
                       output logic [15:0] q, output logic u, output logic ok);
      @(posedge ref_clk);
      req_valid <= 1'b1;
      req_write <= w;
      req_addr  <= a;
      req_wdata <= d;
      @(posedge ref_clk);
      req_valid <= 1'b0;
      req_addr  <= ~a;
      req_wdata <= ~d;
      #1;
      ok = (rsp_valid === 1'b1);
      q  = rsp_rdata;
      u  = rsp_unmapped;
   endtask : xfer
endmodule : tcorm_master_model

// ---- tb/ten_channel_output_register_map_tb.sv ----
module ten_channel_output_register_map_tb;
   timeunit 1ns;
   timeprecision 1ps;

   logic        ref_clk = 1'b0;
   logic        rst_n;
   logic        req_valid, req_write, rsp_valid, rsp_unmapped, lamp, rst_pulse;
   logic [15:0] req_addr, req_wdata, rsp_rdata, supply, q, v;
   logic [9:0]  fault, shorts, chans, m;
   logic [7:0]  dip, node, par, rate, dly, na, en, er;
   logic [31:0] seed = 32'h0001321A;
   logic [31:0] r;
   int          err_count = 0;
   int          compares = 0;

   always #4 ref_clk = ~ref_clk;

   tcorm_master_model u_tcorm_master_model (.ref_clk(ref_clk), .rsp_valid(rsp_valid),
      .rsp_rdata(rsp_rdata), .rsp_unmapped(rsp_unmapped), .req_valid(req_valid),
      .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata));

   tcorm_register_bank u_tcorm_register_bank (.ref_clk(ref_clk), .rst_n(rst_n),
      .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
      .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
      .rsp_unmapped(rsp_unmapped), .channel_fault_pin(fault), .load_short_pin(shorts),
      .dip_switch_pin(dip), .supply_sample(supply), .switched_channels_1_to_10(chans),
      .fault_indicator_lamp(lamp), .node_address(node), .parity_select(par),
      .line_rate_code(rate), .reply_delay(dly), .module_reset_pulse(rst_pulse));

   function logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs

   task tally_and_finish();
      $display("compares %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
      begin
         $display("[ PASS ]");
      end
      else
      begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : tally_and_finish

   task chk(input logic [15:0] g, input logic [15:0] e);
      compares++;
      if (g !== e)
      begin
         err_count++;
         $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk

   // A missing answer is fatal to the sequence, so the run closes at once.
   task acc(input logic w, input logic [15:0] a, input logic [15:0] d, input logic eu);
      logic u;
      logic ok;
      u_tcorm_master_model.xfer(w, a, d, q, u, ok);
      if (ok !== 1'b1)
      begin
         err_count++;
         $display("mismatch at %0t: no answer to request", $time);
         tally_and_finish();
      end
      chk({15'h0000, u}, {15'h0000, eu});
   endtask : acc

   task wr(input logic [15:0] a, input logic [15:0] d);
      acc(1'b1, a, d, 1'b0);
   endtask : wr

   task rd(input logic [15:0] a);
      acc(1'b0, a, 16'h0000, 1'b0);
   endtask : rd

   task pause(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : pause

   initial
   begin
      rst_n  = 1'b0;
      fault  = 10'h000;
      shorts = 10'h000;
      dip    = 8'h00;
      supply = 16'h0000;
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      rd(tcorm_pkg::ADDR_NODE_PARITY);
      chk(q, 16'h0100);
      rd(tcorm_pkg::ADDR_RATE_DELAY);
      chk(q, 16'h0300);
      $display("test reset values done");
      repeat (8)
      begin
         r = xs();
         v = r[15:0];
         wr(tcorm_pkg::ADDR_OUTPUT_DRIVE, v);
         chk({6'h00, chans}, v & tcorm_pkg::CH_MASK);
         rd(tcorm_pkg::ADDR_OUTPUT_DRIVE);
         chk(q, v & tcorm_pkg::CH_MASK);
      end
      $display("test output drive done");
      en = 8'h01;
      er = 8'h03;
      for (int i = 0; i < 9; i++)
      begin
         r  = xs();
         na = (i == 8) ? 8'h00 : (r[15:8] | 8'h01);
         if (na != 8'h00)
         begin
            en = na;
         end
         if (i < 8)
         begin
            er = 8'(i);
         end
         wr(tcorm_pkg::ADDR_NODE_PARITY, {na, r[23:16]});
         chk({node, par}, {en, r[23:16]});
         wr(tcorm_pkg::ADDR_RATE_DELAY, {8'(i), r[7:0]});
         chk({rate, dly}, {er, r[7:0]});
         rd(tcorm_pkg::ADDR_RATE_DELAY);
         chk(q, {er, r[7:0]});
      end
      $display("test configuration done");
      r = xs();
      m = r[9:0] | 10'h201;
      wr(tcorm_pkg::ADDR_DIAG_ENABLE, {6'h00, m});
      @(posedge ref_clk);
      fault <= 10'h3FF;
      pause(4);
      @(posedge ref_clk);
      fault <= 10'h000;
      wr(tcorm_pkg::ADDR_DIAG_ENABLE, 16'h0000);
      pause(3);
      rd(tcorm_pkg::ADDR_CHANNEL_ERROR);
      chk(q, {6'h00, m});
      rd(tcorm_pkg::ADDR_GLOBAL_ERROR);
      chk(q & 16'h0008, 16'h0008);
      wr(tcorm_pkg::ADDR_CHANNEL_ERROR, 16'hFFFE);
      rd(tcorm_pkg::ADDR_CHANNEL_ERROR);
      chk(q, {6'h00, m & 10'h3FE});
      rd(tcorm_pkg::ADDR_GLOBAL_ERROR);
      chk(q & 16'h0008, 16'h0008);
      wr(tcorm_pkg::ADDR_CHANNEL_ERROR, 16'h0000);
      rd(tcorm_pkg::ADDR_GLOBAL_ERROR);
      chk(q & 16'h0009, 16'h0000);
      $display("test channel errors done");
      r = xs();
      @(posedge ref_clk);
      shorts <= r[9:0] | 10'h001;
      pause(4);
      wr(tcorm_pkg::ADDR_LOAD_SHORT, 16'h0000);
      rd(tcorm_pkg::ADDR_LOAD_SHORT);
      chk(q, {6'h00, r[9:0] | 10'h001});
      rd(tcorm_pkg::ADDR_GLOBAL_ERROR);
      chk(q & 16'h0001, 16'h0001);
      @(posedge ref_clk);
      shorts <= 10'h000;
      supply <= {9'h000, r[16:10]};
      wr(tcorm_pkg::ADDR_SUPPLY_THRESH, 16'h0080);
      wr(tcorm_pkg::ADDR_LED_CONTROL, 16'h0002);
      pause(4);
      chk({15'h0000, lamp}, 16'h0001);
      rd(tcorm_pkg::ADDR_SUPPLY_MEASURE);
      chk(q, {9'h000, r[16:10]});
      rd(tcorm_pkg::ADDR_GLOBAL_ERROR);
      chk(q, 16'h0040);
      wr(tcorm_pkg::ADDR_LED_CONTROL, 16'h0000);
      pause(2);
      chk({15'h0000, lamp}, 16'h0000);
      $display("test shorts and supply done");
      r = xs();
      @(posedge ref_clk);
      dip <= r[7:0];
      pause(3);
      wr(tcorm_pkg::ADDR_COMMAND, tcorm_pkg::CMD_SWITCH_CAPTURE);
      @(posedge ref_clk);
      dip <= ~r[7:0];
      pause(3);
      wr(tcorm_pkg::ADDR_CAPTURE, 16'hFFFF);
      rd(tcorm_pkg::ADDR_CAPTURE);
      chk(q, {8'h00, r[7:0]});
      $display("test switch capture done");
      wr(tcorm_pkg::ADDR_OUTPUT_DRIVE, 16'h03FF);
      wr(tcorm_pkg::ADDR_COMMAND, tcorm_pkg::CMD_MODULE_RESET);
      chk({15'h0000, rst_pulse}, 16'h0001);
      pause(1);
      chk({6'h00, chans}, 16'h0000);
      acc(1'b0, 16'h9C45, 16'h0000, 1'b1);
      chk(q, 16'h0000);
      acc(1'b1, 16'h9C45, 16'hFFFF, 1'b1);
      $display("test module reset and unmapped done");
      tally_and_finish();
   end
endmodule : ten_channel_output_register_map_tb
